// [rtl/usart_smartcard_multidrop_ctrl.sv]
// smart card and rs-485 multidrop mode control with apb registers
// assumes a usart core that reports characters and supplies etu ticks
`timescale 1ns/100ps
module usart_smartcard_multidrop_ctrl (
	input wire logic pclk, // apb clock, 50 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [31:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire usart_scmd_pkg::rx_char_t rx_char, // received character
	input wire logic tx_char_done, // character sent, pulse
	input wire logic etu_tick, // one pulse per etu
	output usart_scmd_pkg::sc_cfg_t sc_cfg, // smart card settings
	output logic multidrop_mode, // normal multidrop mode on
	output logic tx_hold, // guard time running
	output logic sc_io_out, // card line level while driven
	output logic sc_io_oe, // card line driven
	output logic irq // interrupt, level
);
	localparam int IW = usart_scmd_pkg::IRQ_W;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic [4:0] reg_sel(input logic [31:0] a);
		logic [4:0] s;
		s = 5'h00;
		unique case (a)
			usart_scmd_pkg::SC_CTRL_ADDR: s = 5'h01;
			usart_scmd_pkg::MD_CTRL_ADDR: s = 5'h02;
			usart_scmd_pkg::IRQ_STAT_ADDR: s = 5'h04;
			usart_scmd_pkg::IRQ_MASK_ADDR: s = 5'h08;
			usart_scmd_pkg::MD_ADDR_ADDR: s = 5'h10;
			default: s = 5'h00;
		endcase
		return s;
	endfunction : reg_sel

	logic [4:0] sel;
	logic wr, rd_start;
	logic [IW-1:0] irq_status, next_irq_status;
	logic [IW-1:0] irq_mask, next_irq_mask;
	logic [IW-1:0] ev, w1c;
	logic [7:0] addr_byte, next_addr_byte;
	usart_scmd_pkg::sc_cfg_t next_sc_cfg;
	logic next_multidrop_mode, next_irq;
	logic next_pready, next_pslverr;
	logic [31:0] next_prdata, rdata;
	logic guard_done, nack_sent;

	// ----------------------------------------
	// mode engines
	// ----------------------------------------
	usart_sc_guard u_guard (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(sc_cfg),
		.tx_char_done(tx_char_done),
		.etu_tick(etu_tick),
		.busy(tx_hold),
		.done(guard_done)
	);

	usart_sc_nack u_nack (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(sc_cfg),
		.rx_char(rx_char),
		.etu_tick(etu_tick),
		.line_out(sc_io_out),
		.line_oe(sc_io_oe),
		.sent(nack_sent)
	);

	// ----------------------------------------
	// registers and events
	// ----------------------------------------
	always_comb begin
		sel = reg_sel(paddr);
		// writes land on the edge that completes the access
		wr = psel && penable && pready && pwrite;
		next_sc_cfg = sc_cfg;
		next_multidrop_mode = multidrop_mode;
		next_irq_mask = irq_mask;
		w1c = '0;
		if (wr && sel[0]) begin
			next_sc_cfg.smartcard_enable = pwdata[usart_scmd_pkg::SC_EN_POS]; // RQ1
			next_sc_cfg.nack_inhibit = pwdata[usart_scmd_pkg::NACK_INH_POS]; // RQ2
			next_sc_cfg.protocol_select = pwdata[usart_scmd_pkg::PROT_POS]; // RQ3
			next_sc_cfg.extra_guard_etus =
				pwdata[usart_scmd_pkg::XG_MSB:usart_scmd_pkg::XG_LSB]; // RQ4
		end
		if (wr && sel[1])
			next_multidrop_mode = pwdata[usart_scmd_pkg::MD_EN_POS]; // RQ6
		if (wr && sel[2])
			w1c = pwdata[IW-1:0];
		if (wr && sel[3])
			next_irq_mask = pwdata[IW-1:0];
		ev = '0;
		ev[usart_scmd_pkg::IRQ_ADDR_POS] =
			multidrop_mode && rx_char.done && rx_char.parity_err; // RQ6
		ev[usart_scmd_pkg::IRQ_NACK_POS] = nack_sent;
		ev[usart_scmd_pkg::IRQ_GUARD_POS] = guard_done;
		// a new event outranks a clear in the same cycle
		next_irq_status = (irq_status & ~w1c) | ev;
		next_addr_byte = ev[usart_scmd_pkg::IRQ_ADDR_POS] ? rx_char.data : addr_byte; // RQ6
		next_irq = |(next_irq_status & next_irq_mask); // RQ6
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sc_cfg <= usart_scmd_pkg::SC_CFG_RST;
			multidrop_mode <= usart_scmd_pkg::MD_EN_RST;
			irq_mask <= usart_scmd_pkg::IRQ_MASK_RST;
			irq_status <= '0;
			addr_byte <= 8'h00;
			irq <= 1'b0;
		end else begin
			sc_cfg <= next_sc_cfg;
			multidrop_mode <= next_multidrop_mode;
			irq_mask <= next_irq_mask;
			irq_status <= next_irq_status;
			addr_byte <= next_addr_byte;
			irq <= next_irq;
		end
	end

	// ----------------------------------------
	// apb answer
	// ----------------------------------------
	always_comb begin
		rdata = 32'h0000_0000;
		if (sel[0]) begin
			rdata[usart_scmd_pkg::SC_EN_POS] = sc_cfg.smartcard_enable;
			rdata[usart_scmd_pkg::NACK_INH_POS] = sc_cfg.nack_inhibit;
			rdata[usart_scmd_pkg::PROT_POS] = sc_cfg.protocol_select;
			rdata[usart_scmd_pkg::XG_MSB:usart_scmd_pkg::XG_LSB] =
				sc_cfg.extra_guard_etus;
		end
		if (sel[1])
			rdata[usart_scmd_pkg::MD_EN_POS] = multidrop_mode;
		if (sel[2])
			rdata[IW-1:0] = irq_status;
		if (sel[3])
			rdata[IW-1:0] = irq_mask;
		if (sel[4])
			rdata[7:0] = addr_byte;
		// one wait state: ready rises in the second access cycle
		rd_start = psel && penable && !pready;
		next_pready = rd_start;
		next_pslverr = rd_start && (sel == 5'h00);
		next_prdata = (rd_start && !pwrite) ? rdata : 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_addr_event;
		multidrop_mode && rx_char.done && rx_char.parity_err
			|=> irq_status[0] && addr_byte == $past(rx_char.data);
	endproperty
	a_addr_event: assert property (p_addr_event) else $error("address byte not flagged"); // RQ6

	property p_no_mdm_addr;
		!multidrop_mode && !irq_status[0] && !(wr && sel[2]) |=> !irq_status[0];
	endproperty
	a_no_mdm_addr: assert property (p_no_mdm_addr) else $error("address flag without mode"); // RQ6

	property p_irq_level;
		irq == |(irq_status & irq_mask);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level mismatch"); // RQ6

	property p_set_wins;
		ev[0] && wr && sel[2] && pwdata[0] |=> irq_status[0];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost under clear");

	property p_sc_write;
		wr && sel[0] |=> sc_cfg.smartcard_enable == $past(pwdata[0])
			&& sc_cfg.protocol_select == $past(pwdata[2]);
	endproperty
	a_sc_write: assert property (p_sc_write) else $error("smart card write lost"); // RQ3

	// ----------------------------------------
	// bus and register checks
	// ----------------------------------------
	// single wait state: software may rely on a fixed access length
	property p_ready_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready missing after wait");

	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

	property p_prdata_idle;
		!pready |-> prdata == 32'h0000_0000;
	endproperty
	a_prdata_idle: assert property (p_prdata_idle) else $error("read data outside answer");

	property p_slverr_ready;
		pslverr |-> pready;
	endproperty
	a_slverr_ready: assert property (p_slverr_ready) else $error("error without ready");

	property p_unmapped_quiet;
		wr && sel == 5'h00 |=> $stable(sc_cfg) && $stable(multidrop_mode) && $stable(irq_mask);
	endproperty
	a_unmapped_quiet: assert property (p_unmapped_quiet) else $error("unmapped write landed");

	property p_cfg_hold;
		!(wr && sel[0]) |=> $stable(sc_cfg);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("smart card setting drifted"); // RQ1

	property p_inh_write;
		wr && sel[0]
			|=> sc_cfg.nack_inhibit == $past(pwdata[usart_scmd_pkg::NACK_INH_POS]);
	endproperty
	a_inh_write: assert property (p_inh_write) else $error("nack inhibit write lost"); // RQ2

	property p_xg_write;
		wr && sel[0] |=> sc_cfg.extra_guard_etus
			== $past(pwdata[usart_scmd_pkg::XG_MSB:usart_scmd_pkg::XG_LSB]);
	endproperty
	a_xg_write: assert property (p_xg_write) else $error("extra guard write lost"); // RQ4

	property p_md_write;
		wr && sel[1] |=> multidrop_mode == $past(pwdata[usart_scmd_pkg::MD_EN_POS]);
	endproperty
	a_md_write: assert property (p_md_write) else $error("multidrop write lost"); // RQ6

	property p_md_hold;
		!(wr && sel[1]) |=> $stable(multidrop_mode);
	endproperty
	a_md_hold: assert property (p_md_hold) else $error("multidrop mode drifted"); // RQ6

	property p_mask_write;
		wr && sel[3] |=> irq_mask == $past(pwdata[IW-1:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // RQ6

	property p_w1c;
		wr && sel[2] && pwdata[usart_scmd_pkg::IRQ_ADDR_POS]
			&& !ev[usart_scmd_pkg::IRQ_ADDR_POS] |=> !irq_status[usart_scmd_pkg::IRQ_ADDR_POS];
	endproperty
	a_w1c: assert property (p_w1c) else $error("address flag not cleared"); // RQ6

	property p_status_hold;
		!(wr && sel[2]) && ev == '0 |=> $stable(irq_status);
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status changed unprompted");

	property p_nack_flag;
		nack_sent |=> irq_status[usart_scmd_pkg::IRQ_NACK_POS];
	endproperty
	a_nack_flag: assert property (p_nack_flag) else $error("nack event not flagged"); // RQ8

	property p_guard_flag;
		guard_done |=> irq_status[usart_scmd_pkg::IRQ_GUARD_POS];
	endproperty
	a_guard_flag: assert property (p_guard_flag) else $error("guard event not flagged"); // RQ4

	property p_addr_hold;
		!ev[usart_scmd_pkg::IRQ_ADDR_POS] |=> $stable(addr_byte);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address byte overwritten"); // RQ6

	property p_irq_masked;
		irq_mask == '0 |-> !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("irq with all masked"); // RQ6

	// the line is only ever pulled low; the pull-up gives the high level
	property p_line_low;
		sc_io_oe |-> !sc_io_out;
	endproperty
	a_line_low: assert property (p_line_low) else $error("card line driven high"); // RQ8

	property p_guard_enable;
		$rose(tx_hold) |-> $past(sc_cfg.smartcard_enable);
	endproperty
	a_guard_enable: assert property (p_guard_enable) else $error("guard without enable"); // RQ1

	c_addr_irq: cover property (ev[0] && irq_mask[0] ##1 irq);
	c_nack_line: cover property ($rose(sc_io_oe) ##[1:8] nack_sent);
	c_read: cover property (psel && !pwrite && sel[0] ##[1:3] pready);

endmodule : usart_smartcard_multidrop_ctrl

// [rtl/usart_scmd_pkg.sv]
// usart smart card and multidrop control: shared constants and types
// assumes an apb slave at 50 MHz and a usart core giving etu ticks
//
// Contract
// RQ1 - enable bit selects smart card mode, resets 0
// RQ2 - nack inhibit bit suppresses nack, t0 only
// RQ3 - protocol bit: 0 is t0, 1 is t1
// RQ4 - t0 guard is 2 etus plus extra field
// RQ5 - extra field 0xff gives single-bit guard
// RQ6 - multidrop: parity-flagged byte is address, interrupts
// RQ7 - software keeps half-duplex enable cleared meanwhile
// RQ8 - t0 parity error answered by nack in guard
package usart_scmd_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [31:0] SC_CTRL_ADDR = 32'h4000_8048;
	localparam logic [31:0] MD_CTRL_ADDR = 32'h4000_804c;
	localparam logic [31:0] IRQ_STAT_ADDR = 32'h4000_8070;
	localparam logic [31:0] IRQ_MASK_ADDR = 32'h4000_8074;
	localparam logic [31:0] MD_ADDR_ADDR = 32'h4000_8078;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int SC_EN_POS = 0;
	localparam int NACK_INH_POS = 1;
	localparam int PROT_POS = 2;
	localparam int XG_LSB = 8;
	localparam int XG_MSB = 15;
	localparam int MD_EN_POS = 0;
	localparam int IRQ_ADDR_POS = 0;
	localparam int IRQ_NACK_POS = 1;
	localparam int IRQ_GUARD_POS = 2;
	localparam int IRQ_W = 3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	localparam logic MD_EN_RST = 1'h0;

	// ----------------------------------------
	// timing in etus
	// ----------------------------------------
	localparam int GUARD_W = 9;
	localparam logic [7:0] XG_SINGLE = 8'hff;
	localparam logic [GUARD_W-1:0] GUARD_NOM_ETUS = 9'h002;
	localparam logic [GUARD_W-1:0] GUARD_SINGLE_ETUS = 9'h001;
	localparam logic [1:0] NACK_ETUS = 2'h1;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] extra_guard_etus;
		logic protocol_select;
		logic nack_inhibit;
		logic smartcard_enable;
	} sc_cfg_t;

	localparam sc_cfg_t SC_CFG_RST = '{8'h00, 1'h0, 1'h0, 1'h0};

	typedef struct packed {
		logic done;
		logic parity_err;
		logic [7:0] data;
	} rx_char_t;

endpackage : usart_scmd_pkg

// [rtl/usart_sc_guard.sv]
// guard time timer after each transmitted smart card character
// assumes etu_tick pulses once per bit time from the baud logic
`timescale 1ns/100ps
module usart_sc_guard (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire usart_scmd_pkg::sc_cfg_t cfg, // smart card settings
	input wire logic tx_char_done, // character sent, pulse
	input wire logic etu_tick, // one pulse per etu
	output logic busy, // guard running, holds off transmitter
	output logic done // guard ended, pulse
);
	typedef enum logic [1:0] {G_IDLE = 2'b01, G_RUN = 2'b10} guard_state_t;
	guard_state_t state, next_state;
	logic [usart_scmd_pkg::GUARD_W-1:0] left, next_left, len;
	logic next_busy, next_done, start;

	always_comb begin
		if (cfg.protocol_select)
			len = usart_scmd_pkg::GUARD_NOM_ETUS; // RQ3
		else if (cfg.extra_guard_etus == usart_scmd_pkg::XG_SINGLE)
			len = usart_scmd_pkg::GUARD_SINGLE_ETUS; // RQ5
		else
			len = usart_scmd_pkg::GUARD_NOM_ETUS + {1'h0, cfg.extra_guard_etus}; // RQ4
		start = (state == G_IDLE) && tx_char_done && cfg.smartcard_enable; // RQ1
		next_state = state;
		next_left = left;
		next_done = 1'b0;
		unique case (state)
			G_IDLE: begin
				if (start) begin
					next_state = G_RUN;
					next_left = len;
				end
			end
			G_RUN: begin
				if (etu_tick) begin
					next_left = left - 9'h001;
					if (left == 9'h001) begin
						next_state = G_IDLE;
						next_done = 1'b1;
					end
				end
			end
		endcase
		next_busy = (next_state == G_RUN);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= G_IDLE;
			left <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			left <= next_left;
			busy <= next_busy;
			done <= next_done;
		end
	end

	// helper: ticks seen in one guard period
	logic [usart_scmd_pkg::GUARD_W-1:0] ticks, want;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ticks <= '0;
			want <= '0;
		end else if (start) begin
			ticks <= '0;
			want <= len;
		end else if (state == G_RUN && etu_tick) begin
			ticks <= ticks + 9'h001;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_t1_nominal;
		start && cfg.protocol_select |=> left == usart_scmd_pkg::GUARD_NOM_ETUS;
	endproperty
	a_t1_nominal: assert property (p_t1_nominal) else $error("t1 guard not nominal"); // RQ3

	property p_t0_extra;
		start && !cfg.protocol_select && cfg.extra_guard_etus != usart_scmd_pkg::XG_SINGLE
			|=> left == usart_scmd_pkg::GUARD_NOM_ETUS + {1'h0, $past(cfg.extra_guard_etus)};
	endproperty
	a_t0_extra: assert property (p_t0_extra) else $error("t0 guard length wrong"); // RQ4

	property p_single_bit;
		start && !cfg.protocol_select && cfg.extra_guard_etus == usart_scmd_pkg::XG_SINGLE
			|=> left == usart_scmd_pkg::GUARD_SINGLE_ETUS;
	endproperty
	a_single_bit: assert property (p_single_bit) else $error("single-bit guard wrong"); // RQ5

	property p_guard_ticks;
		done |-> ticks == want;
	endproperty
	a_guard_ticks: assert property (p_guard_ticks) else $error("guard tick count off"); // RQ4

	property p_off_no_guard;
		!busy && tx_char_done && !cfg.smartcard_enable |=> !busy;
	endproperty
	a_off_no_guard: assert property (p_off_no_guard) else $error("guard while disabled"); // RQ1

	c_guard_done: cover property (start ##[1:600] done);

endmodule : usart_sc_guard

// [rtl/usart_sc_nack.sv]
// nack generator: pulls the card line low for one etu after a bad character
// assumes the receiver reports parity errors as the character ends
`timescale 1ns/100ps
module usart_sc_nack (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, active low
	input wire usart_scmd_pkg::sc_cfg_t cfg, // smart card settings
	input wire usart_scmd_pkg::rx_char_t rx_char, // received character
	input wire logic etu_tick, // one pulse per etu
	output logic line_out, // card line level while driven
	output logic line_oe, // high while driving the line
	output logic sent // nack finished, pulse
);
	typedef enum logic [2:0] {
		N_IDLE = 3'b001,
		N_WAIT = 3'b010,
		N_DRIVE = 3'b100
	} nack_state_t;
	nack_state_t state, next_state;
	logic [1:0] left, next_left;
	logic next_oe, next_sent, want_nack;

	always_comb begin
		// inhibit and t1 both silence the nack
		want_nack = rx_char.done && rx_char.parity_err && cfg.smartcard_enable // RQ1
			&& !cfg.protocol_select && !cfg.nack_inhibit; // RQ2
		next_state = state;
		next_left = left;
		next_sent = 1'b0;
		unique case (state)
			N_IDLE: begin
				if (want_nack)
					next_state = N_WAIT; // RQ8
			end
			N_WAIT: begin
				// first tick marks the start of the guard period
				if (etu_tick) begin
					next_state = N_DRIVE;
					next_left = usart_scmd_pkg::NACK_ETUS;
				end
			end
			N_DRIVE: begin
				if (etu_tick) begin
					next_left = left - 2'h1;
					if (left == 2'h1) begin
						next_state = N_IDLE;
						next_sent = 1'b1;
					end
				end
			end
		endcase
		next_oe = (next_state == N_DRIVE); // RQ8
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= N_IDLE;
			left <= '0;
			line_oe <= 1'b0;
			sent <= 1'b0;
			line_out <= 1'b0;
		end else begin
			state <= next_state;
			left <= next_left;
			line_oe <= next_oe;
			sent <= next_sent;
			line_out <= 1'b0;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_inhibit;
		state == N_IDLE && rx_char.done && rx_char.parity_err
			&& (cfg.nack_inhibit || cfg.protocol_select) |=> state == N_IDLE;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("nack sent while inhibited"); // RQ2

	property p_drive;
		state == N_WAIT && etu_tick |=> line_oe && !line_out ##1 line_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("nack not driven low"); // RQ8

	property p_off_quiet;
		state == N_IDLE && !cfg.smartcard_enable |=> !line_oe;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("line driven while disabled"); // RQ1

	c_nack: cover property (state == N_WAIT ##[1:600] sent);

endmodule : usart_sc_nack

// [tb/sc_card_model.sv]
// far-side model: usart core, card line and bit timing
// assumes the bench requests characters by one-cycle pulses
`timescale 1ns/100ps
module sc_card_model (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic rx_go, // deliver a received character
	input wire logic rx_bad, // that character has a parity error
	input wire logic [7:0] rx_byte, // character value
	input wire logic tx_go, // report a transmitted character
	input wire logic io_out, // card line level from the block
	input wire logic io_oe, // card line driven by the block
	output usart_scmd_pkg::rx_char_t rx_char, // received character
	output logic tx_char_done, // character sent, pulse
	output logic etu_tick, // one pulse per 4 clocks
	output logic [7:0] low_cnt // cycles the card line was low
);
	logic [1:0] cnt;
	logic line;

	// pull-up holds the line high when released
	assign line = io_oe ? io_out : 1'h1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 2'h0;
			etu_tick <= 1'h0;
			tx_char_done <= 1'h0;
			rx_char <= '0;
			low_cnt <= 8'h00;
		end else begin
			cnt <= cnt + 2'h1;
			etu_tick <= (cnt == 2'h3);
			tx_char_done <= tx_go;
			rx_char.done <= rx_go;
			// junk outside a character, never the last value
			rx_char.parity_err <= rx_go ? rx_bad : ~rx_char.parity_err;
			rx_char.data <= rx_go ? rx_byte : ~rx_char.data;
			if (line == 1'h0) begin
				low_cnt <= low_cnt + 8'h01;
			end
		end
	end
endmodule : sc_card_model

// [tb/usart_smartcard_multidrop_ctrl_test.sv]
// bench for smart card and multidrop control over apb
// assumes one 50 MHz clock and the far-side model beside it
`timescale 1ns/100ps
module usart_smartcard_multidrop_ctrl_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rd;
	usart_scmd_pkg::rx_char_t rx_char;
	usart_scmd_pkg::sc_cfg_t sc_cfg;
	logic tx_char_done, etu_tick, multidrop_mode, tx_hold;
	logic sc_io_out, sc_io_oe, irq, rx_go, rx_bad, tx_go, rerr;
	logic [7:0] rx_byte, low_cnt, low0;
	int err_total, n_tests, nticks;

	usart_smartcard_multidrop_ctrl i_usart_smartcard_multidrop_ctrl (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_char(rx_char), .tx_char_done(tx_char_done),
		.etu_tick(etu_tick), .sc_cfg(sc_cfg), .multidrop_mode(multidrop_mode),
		.tx_hold(tx_hold), .sc_io_out(sc_io_out), .sc_io_oe(sc_io_oe), .irq(irq));

	sc_card_model i_sc_card_model (.pclk(pclk), .presetn(presetn), .rx_go(rx_go),
		.rx_bad(rx_bad), .rx_byte(rx_byte), .tx_go(tx_go), .io_out(sc_io_out),
		.io_oe(sc_io_oe), .rx_char(rx_char), .tx_char_done(tx_char_done),
		.etu_tick(etu_tick), .low_cnt(low_cnt));

	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (tx_hold === 1'h1 && etu_tick === 1'h1) begin
			nticks++;
		end
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task finish_test;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// holds the request until pready, then one idle cycle
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		if (k >= 20) begin
			err_total++;
			finish_test();
		end
		rd = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb

	task pulse_rx(input logic bad, input logic [7:0] b);
		rx_go <= 1'h1;
		rx_bad <= bad;
		rx_byte <= b;
		@(posedge pclk);
		rx_go <= 1'h0;
		repeat (16) @(posedge pclk);
	endtask : pulse_rx

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		apb(1'h0, usart_scmd_pkg::SC_CTRL_ADDR, 32'h0);
		chk("sc reset", 32'h0, rd);
		apb(1'h0, usart_scmd_pkg::MD_CTRL_ADDR, 32'h0);
		chk("md reset", 32'h0, rd);
		apb(1'h1, usart_scmd_pkg::SC_CTRL_ADDR, 32'hffff_ffff);
		apb(1'h0, usart_scmd_pkg::SC_CTRL_ADDR, 32'h0);
		chk("sc rw", 32'h0000_ff07, rd);
		chk("sc cfg", 32'h0000_07ff, {21'h0, sc_cfg});
		apb(1'h0, 32'h4000_8000, 32'h0);
		chk("unmapped", 32'h1, {31'h0, rerr});
	endtask : t_regs

	task t_guard(input logic [31:0] c, input int n);
		int k;
		logic hi;
		apb(1'h1, usart_scmd_pkg::SC_CTRL_ADDR, c);
		nticks = 0;
		hi = 1'h0;
		tx_go <= 1'h1;
		@(posedge pclk);
		tx_go <= 1'h0;
		for (k = 0; k < 80 && !(hi && tx_hold === 1'h0); k++) begin
			@(posedge pclk);
			hi = hi | (tx_hold === 1'h1);
		end
		chk("guard ticks", n, nticks);
	endtask : t_guard

	task t_nack(input logic [31:0] c, input logic bad, input int n);
		apb(1'h1, usart_scmd_pkg::SC_CTRL_ADDR, c);
		low0 = low_cnt;
		pulse_rx(bad, 8'h3c);
		chk("nack low", n, {24'h0, low_cnt - low0});
	endtask : t_nack

	task t_multidrop;
		apb(1'h1, usart_scmd_pkg::SC_CTRL_ADDR, 32'h0);
		apb(1'h0, usart_scmd_pkg::IRQ_STAT_ADDR, 32'h0);
		chk("ev flags", 32'h6, rd);
		apb(1'h1, usart_scmd_pkg::IRQ_STAT_ADDR, 32'h7);
		apb(1'h1, usart_scmd_pkg::MD_CTRL_ADDR, 32'h1);
		chk("md mode", 32'h1, {31'h0, multidrop_mode});
		pulse_rx(1'h0, 8'h5a);
		apb(1'h0, usart_scmd_pkg::IRQ_STAT_ADDR, 32'h0);
		chk("no addr", 32'h0, rd);
		pulse_rx(1'h1, 8'ha5);
		apb(1'h0, usart_scmd_pkg::IRQ_STAT_ADDR, 32'h0);
		chk("addr flag", 32'h1, rd);
		apb(1'h0, usart_scmd_pkg::MD_ADDR_ADDR, 32'h0);
		chk("addr byte", 32'ha5, rd);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'h1, usart_scmd_pkg::IRQ_MASK_ADDR, 32'h1);
		chk("irq set", 32'h1, {31'h0, irq});
		apb(1'h1, usart_scmd_pkg::IRQ_STAT_ADDR, 32'h1);
		chk("irq clear", 32'h0, {31'h0, irq});
	endtask : t_multidrop

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		err_total = 0;
		n_tests = 0;
		nticks = 0;
		presetn = 1'h0;
		{psel, penable, pwrite, rx_go, rx_bad, tx_go} = 6'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		rx_byte = 8'h00;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_regs();
		t_guard(32'h0000_0301, 5);
		t_guard(32'h0000_0001, 2);
		t_guard(32'h0000_ff01, 1);
		t_guard(32'h0000_0305, 2);
		t_guard(32'h0000_0300, 0);
		t_nack(32'h1, 1'h1, 4);
		t_nack(32'h3, 1'h1, 0);
		t_nack(32'h5, 1'h1, 0);
		t_nack(32'h1, 1'h0, 0);
		t_nack(32'h0, 1'h1, 0);
		t_multidrop();
		finish_test();
	end
endmodule : usart_smartcard_multidrop_ctrl_test
